// ### pkg/sbrg_consts.vh
// Purpose: Register offsets, field positions, reset values and divide factors of the baud generator.
// Assumes: 32-bit AXI4-Lite register words, one per aligned word.
// Notes:   Definitions only.
`ifndef SBRG_CONSTS_VH
`define SBRG_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SBRG_OFF_DIV_LOW    4'h0
`define SBRG_OFF_DIV_HIGH   4'h4
`define SBRG_OFF_CTRL       4'h8
`define SBRG_OFF_STATUS     4'hc

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define SBRG_CTRL_SYNC_BIT  0
`define SBRG_CTRL_WIDE_BIT  1
`define SBRG_CTRL_HS_BIT    2
`define SBRG_CTRL_MASTER_BIT 3
`define SBRG_CTRL_ENABLE_BIT 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBRG_RST_DIV_LOW    8'h00
`define SBRG_RST_DIV_HIGH   8'h00
`define SBRG_RST_CTRL       5'h00

// ----------------------------------------
// Prescale factors, coded as the prescaler's terminal count
// ----------------------------------------
`define SBRG_PRE_64         6'h3f
`define SBRG_PRE_16         6'h0f
`define SBRG_PRE_4          6'h03

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define SBRG_RESP_OKAY      2'h0
`define SBRG_RESP_SLVERR    2'h2

`endif

// ### src/sbrg_divider.v
// Purpose: Two-stage divider: prescaler then sixteen-bit divisor counter.
// Assumes: One clock; restart is a one-cycle pulse from the register block.
// Notes:   Tick period is (pre_tc + 1) * (divisor + 1) clock cycles.
`timescale 1ns/1ps
module sbrg_divider (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        enable,
  input  wire        restart,
  input  wire [5:0]  pre_tc,
  input  wire [15:0] divisor,
  output reg         tick_reg
);

  reg  [5:0]  pre_reg;
  reg  [15:0] cnt_reg;
  wire        pre_end;

  assign pre_end = (pre_reg >= pre_tc);

  // The counter is compared with >= so a divisor lowered mid-period ends the
  // current period at the next prescaler end instead of wrapping through the full range.
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_reg  <= 6'h00;
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (restart || !enable) begin
      pre_reg  <= 6'h00;
      cnt_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (pre_end) begin
        pre_reg <= 6'h00;
        if (cnt_reg >= divisor) begin
          cnt_reg  <= 16'h0000;
          tick_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 16'h0001;
        end
      end else begin
        pre_reg <= pre_reg + 6'h01;
      end
    end
  end

endmodule

// ### src/sbrg_top.v
// Purpose: Baud rate generator of a serial port with an AXI4-Lite register slave.
// Assumes: aclk at 10 MHz, synchronous active-low aresetn, single-beat bus master.
// Notes:   Outputs a one-cycle bit-rate tick and, in synchronous master mode, a clock.
//
// Functional notes
// - High divisor register holds divisor bits fifteen down to eight.
// - High divisor byte ignored unless wide-divisor select is set.
// - Writing the high divisor register restarts the baud counter.
// - Divisor is high register concatenated above low register.
// - Asynchronous, 8-bit, low speed: rate is clock over 64(n+1).
// - Asynchronous, 16-bit, low speed: rate is clock over 16(n+1).
// - Synchronous mode: rate is clock over 4(n+1), any width or speed.
// - Writing the low divisor register restarts the baud counter.
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`include "sbrg_consts.vh"
module sbrg_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [3:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        baud_tick,
  output reg         sync_clk_out_reg
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [7:0]  div_low_reg;
  reg  [7:0]  div_high_reg;
  reg  [4:0]  ctrl_reg;
  reg  [3:0]  aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;
  reg         restart_reg;
  reg  [15:0] tick_cnt_reg;

  wire        sync_mode;
  wire        wide_sel;
  wire        hs_sel;
  wire        enable;
  wire        do_write;
  wire        wr_lane0;
  wire [15:0] divisor;
  reg  [5:0]  pre_tc;

  assign sync_mode = ctrl_reg[`SBRG_CTRL_SYNC_BIT];
  assign wide_sel  = ctrl_reg[`SBRG_CTRL_WIDE_BIT];
  assign hs_sel    = ctrl_reg[`SBRG_CTRL_HS_BIT];
  assign enable    = ctrl_reg[`SBRG_CTRL_ENABLE_BIT];

  // ----------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign do_write      = aw_held_reg && w_held_reg;
  assign wr_lane0      = w_strb_reg[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SBRG_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_reg)
          `SBRG_OFF_DIV_LOW,
          `SBRG_OFF_DIV_HIGH,
          `SBRG_OFF_CTRL,
          `SBRG_OFF_STATUS: s_axi_bresp <= `SBRG_RESP_OKAY;
          default:          s_axi_bresp <= `SBRG_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  // A write to either divisor byte restarts the counter even when the strobe
  // leaves the byte unchanged, since the access itself is the restart event.
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_low_reg  <= `SBRG_RST_DIV_LOW;
      div_high_reg <= `SBRG_RST_DIV_HIGH;
      ctrl_reg     <= `SBRG_RST_CTRL;
      restart_reg  <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      if (do_write) begin
        case (aw_addr_reg)
          `SBRG_OFF_DIV_LOW: begin
            if (wr_lane0) begin
              div_low_reg <= w_data_reg[7:0];
            end
            restart_reg <= 1'b1;
          end
          `SBRG_OFF_DIV_HIGH: begin
            if (wr_lane0) begin
              div_high_reg <= w_data_reg[7:0];
            end
            restart_reg <= 1'b1;
          end
          `SBRG_OFF_CTRL: begin
            if (wr_lane0) begin
              ctrl_reg <= w_data_reg[4:0];
            end
          end
          default: begin
            restart_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Rate selection
  // ----------------------------------------
  assign divisor = wide_sel ? {div_high_reg, div_low_reg} : {8'h00, div_low_reg};

  always @* begin
    pre_tc = `SBRG_PRE_64;
    if (sync_mode) begin
      pre_tc = `SBRG_PRE_4;
    end else if (!hs_sel) begin
      pre_tc = wide_sel ? `SBRG_PRE_16 : `SBRG_PRE_64;
    end else begin
      pre_tc = wide_sel ? `SBRG_PRE_4 : `SBRG_PRE_16;
    end
  end

  sbrg_divider u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .enable   (enable),
    .restart  (restart_reg),
    .pre_tc   (pre_tc),
    .divisor  (divisor),
    .tick_reg (baud_tick)
  );

  // ----------------------------------------
  // Synchronous master clock and tick counter
  // ----------------------------------------
  // The clock toggles per tick, so one clock period spans two bit-rate ticks.
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_clk_out_reg <= 1'b0;
      tick_cnt_reg     <= 16'h0000;
    end else begin
      if (!(sync_mode && ctrl_reg[`SBRG_CTRL_MASTER_BIT]) || restart_reg) begin
        sync_clk_out_reg <= 1'b0;
      end else if (baud_tick) begin
        sync_clk_out_reg <= !sync_clk_out_reg;
      end
      if (baud_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `SBRG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `SBRG_RESP_OKAY;
      case (s_axi_araddr)
        `SBRG_OFF_DIV_LOW:  s_axi_rdata <= {24'h000000, div_low_reg};
        `SBRG_OFF_DIV_HIGH: s_axi_rdata <= {24'h000000, div_high_reg};
        `SBRG_OFF_CTRL:     s_axi_rdata <= {27'h0000000, ctrl_reg};
        `SBRG_OFF_STATUS:   s_axi_rdata <= {16'h0000, tick_cnt_reg};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SBRG_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ### verification/sbrg_checker.sv
// Purpose: Bus handshake and tick spacing checks on the baud generator ports.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Bound to the top module from the bench top file.
`timescale 1ns/1ps
module sbrg_checker (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire       baud_tick,
  input wire       sync_clk_out_reg
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_aw_held: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address taken while a response is pending");
  a_w_held: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("write data taken while a response is pending");
  a_ar_held: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data is pending");
  a_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  a_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read data dropped before it was taken");
  a_r_data: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  // The master clock may only rise one cycle after a bit-rate tick.
  a_clk_rise: assert property ($rose(sync_clk_out_reg) |-> $past(baud_tick))
    else $error("synchronous clock rose without a tick");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  // The shortest legal bit period is four clocks, so ticks never crowd closer.
  a_tick_gap: assert property (baud_tick |=> !baud_tick [*3])
    else $error("ticks closer than the smallest divide factor");
endmodule

// ### verification/tb_sbrg_top.sv
// Purpose: Self-checking bench for the baud generator registers and divider.
// Assumes: 100 ns clock, reset held for five cycles.
// Notes:   Tick periods are compared with a model of the rate formulas.
`timescale 1ns/1ps
`include "sbrg_consts.vh"
module tb_sbrg_top;
  logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [3:0]  s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [2:0]  s_axi_awprot = 0, s_axi_arprot = 0;
  logic [31:0] s_axi_wdata = 0, x = 32'h44, rd;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         baud_tick, sync_clk_out_reg;
  logic [7:0]  h, l;
  logic        sc;
  logic [1:0]  rsp;
  int          fails = 0, n_checks = 0, m, per, gap, n_ticks = 0;
  sbrg_top u_sbrg_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .baud_tick, .sync_clk_out_reg);
  initial forever #50 aclk = ~aclk;
  // Bench's own count of bit-rate ticks, compared with the status register.
  always @(negedge aclk) if (baud_tick === 1'b1) n_ticks++;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic int model(logic [2:0] c, logic [7:0] hi, logic [7:0] lo);
    int p;
    p = c[0] ? 4 : (c[1] ? (c[2] ? 4 : 16) : (c[2] ? 16 : 64));
    return p * ((c[1] ? {hi, lo} : {8'h00, lo}) + 1);
  endfunction
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
    if (s == "timeout") report_and_stop();
  endtask
  // The response ready is raised late on purpose so the slave must hold its answer.
  task automatic wr(logic [3:0] a, logic [31:0] d);
    int i;
    bit ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 999 && !tb; i++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid && s_axi_bready;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) s_axi_bready <= 0;
      else s_axi_bready <= i > 1;
    end
    if (i >= 999) chk("timeout", 0, 1);
  endtask
  task automatic rdr(logic [3:0] a);
    int i;
    bit ta, tb;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 999 && !tb; i++) begin
      @(negedge aclk);
      ta = s_axi_arready;
      tb = s_axi_rvalid && s_axi_rready;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
      if (tb) s_axi_rready <= 0;
      else s_axi_rready <= i > 1;
    end
    if (i >= 999) chk("timeout", 0, 1);
  endtask
  task automatic tk(output int n);
    for (n = 0; n < 20000; n++) begin
      @(negedge aclk);
      if (baud_tick === 1'b1) break;
    end
    if (n >= 20000) chk("timeout", 0, 1);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    for (m = 0; m < 4; m++) begin
      rdr(4'(m * 4));
      chk("reset_value", 0, rd);
      chk("rresp", `SBRG_RESP_OKAY, rsp);
    end
    for (m = 0; m < 8; m++) begin
      l = 8'(xs() & 32'h3);
      h = 8'h01 + 8'(xs() & 32'h1);
      wr(`SBRG_OFF_DIV_LOW, {24'h0, l});
      wr(`SBRG_OFF_DIV_HIGH, {24'h0, h});
      rdr(`SBRG_OFF_DIV_HIGH);
      chk("div_high", {24'h0, h}, rd);
      wr(`SBRG_OFF_CTRL, 32'h18 | m);
      chk("bresp", `SBRG_RESP_OKAY, rsp);
      tk(gap);
      sc = sync_clk_out_reg;
      tk(per);
      chk("period", model(m[2:0], h, l), per + 1);
      chk("sync_clk", m[0] ? !sc : 1'b0, sync_clk_out_reg);
    end
    wr(`SBRG_OFF_CTRL, 32'h10);
    for (m = 0; m < 2; m++) begin
      wr(`SBRG_OFF_DIV_LOW, 32'h3);
      tk(gap);
      repeat (100) @(posedge aclk);
      // First pass writes the low byte with its lane strobe off: no update, yet a restart; second pass writes the high byte.
      s_axi_wstrb <= m ? 4'hf : 4'h0;
      wr(m ? `SBRG_OFF_DIV_HIGH : `SBRG_OFF_DIV_LOW, m ? 32'h0 : 32'h7);
      s_axi_wstrb <= 4'hf;
      tk(gap);
      chk("restart_gap", 1, gap > 244 && gap < 259);
    end
    rdr(`SBRG_OFF_DIV_LOW);
    chk("div_low", 32'h3, rd);
    wr(4'h2, 32'hff);
    chk("bresp_unmapped", `SBRG_RESP_SLVERR, rsp);
    rdr(4'h2);
    chk("rresp_unmapped", `SBRG_RESP_SLVERR, rsp);
    chk("rdata_unmapped", 0, rd);
    wr(`SBRG_OFF_CTRL, 32'h0);
    rdr(`SBRG_OFF_STATUS);
    chk("tick_count", n_ticks % 65536, rd);
    report_and_stop();
  end
endmodule
bind sbrg_top sbrg_checker u_sbrg_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .baud_tick, .sync_clk_out_reg);
